/* File: src/ipd_debounce.sv */
// Purpose: Input filter for one discrete input port.
// Assumes: Input already synchronous to clk.
// Notes: Unless bypass is set, a change passes only after it stays stable for HOLD cycles.
`timescale 1ns/1ns
`default_nettype none

module ipd_debounce #(
  parameter int HOLD = 16
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic bypass,
  input wire logic rawIn,
  output logic cleanOut
);

  localparam int CW = $clog2(HOLD + 1);

  typedef struct packed {
    logic out;
    logic [CW-1:0] cnt;
  } ipd_flt_s;

  ipd_flt_s s_r;
  ipd_flt_s s_nxt;

  always_comb begin
    s_nxt = s_r;
    if (bypass) begin
      s_nxt.out = rawIn;
      s_nxt.cnt = '0;
    end else if (rawIn == s_r.out) begin
      s_nxt.cnt = '0;
    end else if (s_r.cnt == CW'(HOLD - 1)) begin
      s_nxt.out = rawIn;
      s_nxt.cnt = '0;
    end else begin
      s_nxt.cnt = s_r.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cleanOut = s_r.out;

endmodule

`default_nettype wire

/* File: src/ipd_input_dispatch.sv */
// Purpose: Turns discrete input port levels and edges into controller actions.
// Assumes: APB slave, zero wait states; inputs synchronous to clk.
// Notes: Each port gets a function value through its own register.
`timescale 1ns/1ns
`default_nettype none

module ipd_input_dispatch #(
  parameter int NPORTS = ipd_pkg::NPORTS_DEF,
  parameter int FILT_CYCLES = ipd_pkg::FILT_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ipd_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NPORTS-1:0] discreteInputPort,
  input wire logic frontManual,
  input wire logic errorRaise,
  input wire logic [ipd_pkg::NAXES-1:0] cutoffCause,
  output logic errorActive,
  output logic [ipd_pkg::NAXES-1:0] driveCutoff,
  output logic [ipd_pkg::NAXES-1:0] homeStart,
  output logic [ipd_pkg::NAXES-1:0] brakeRelease,
  output logic manualOperationMode,
  output logic hostOrPendantPermit,
  output logic [6:0] progHighNumber
);

  import ipd_pkg::*;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [CTRL_W-1:0] ctrl;
    logic [AXCFG_W-1:0] axcfg;
    logic [NPORTS-1:0][FUNC_W-1:0] func;
    logic [NPORTS-1:0] prevIn;
    logic errorActive;
    logic [NAXES-1:0] cutoff;
    logic [NAXES-1:0] homeStart;
    logic [NAXES-1:0] brake;
    logic manual;
    logic permit;
    logic [6:0] progHigh;
  } ipd_state_s;

  ipd_state_s s_r;
  ipd_state_s s_nxt;

  logic [NPORTS-1:0] filtered;
  logic [NPORTS-1:0] bypass;

  // Ports carrying one function value.
  function automatic logic [NPORTS-1:0] portsWith(
    input logic [NPORTS-1:0][FUNC_W-1:0] fs,
    input logic [FUNC_W-1:0] code
  );
    logic [NPORTS-1:0] m;
    m = '0;
    for (int i = 0; i < NPORTS; i++) begin
      m[i] = (fs[i] == code);
    end
    return m;
  endfunction

  // Byte address of a port's function register.
  function automatic logic [APB_AW-1:0] funcAddr(input int idx);
    return APB_AW'(REG_FUNC_BASE) + APB_AW'(idx * 4);
  endfunction

  genvar g;
  generate
    for (g = 0; g < NPORTS; g++) begin : gPort
      // The remote-mode port skips the filter so mode changes are not held for the filter time.
      assign bypass[g] = (s_r.func[g] == FN_REMOTE) || !s_r.ctrl[CTRL_FILTEN];
      ipd_debounce #(
        .HOLD(FILT_CYCLES)
      ) uFilter (
        .clk(clk),
        .reset(reset),
        .bypass(bypass[g]),
        .rawIn(discreteInputPort[g]),
        .cleanOut(filtered[g])
      );
    end
  endgenerate

  always_comb begin
    logic [NPORTS-1:0] rise;
    logic lvP5;
    logic lvP6;
    logic lvP7;
    logic rsErr;
    logic rsCut;
    logic rsHomeAll;
    logic rsHomeInc;
    logic lvPermit;
    logic lvRemote;
    logic [NAXES-1:0] rawBrake;
    logic [NAXES-1:0] valid;
    logic [NAXES-1:0] incr;
    logic [NAXES-1:0] intDrv;
    logic [31:0] rdata;
    logic hit;
    rise = '0;
    lvP5 = 1'b0;
    lvP6 = 1'b0;
    lvP7 = 1'b0;
    rsErr = 1'b0;
    rsCut = 1'b0;
    rsHomeAll = 1'b0;
    rsHomeInc = 1'b0;
    lvPermit = 1'b0;
    lvRemote = 1'b0;
    rawBrake = '0;
    valid = '0;
    incr = '0;
    intDrv = '0;
    rdata = '0;
    hit = 1'b0;

    s_nxt = s_r;
    s_nxt.pready = 1'b0;
    s_nxt.pslverr = 1'b0;
    s_nxt.homeStart = '0;

    // Edges come from the filtered sample against last cycle's sample.
    rise = filtered & ~s_r.prevIn;
    s_nxt.prevIn = filtered;

    // Values 24 to 27 and above match no decode below and so do nothing.
    lvP5 = |(filtered & portsWith(s_r.func, FN_PROG5));
    lvP6 = |(filtered & portsWith(s_r.func, FN_PROG6));
    lvP7 = |(filtered & portsWith(s_r.func, FN_PROG7));
    rsErr = |(rise & portsWith(s_r.func, FN_ERRRST));
    rsCut = |(rise & portsWith(s_r.func, FN_CUTRST));
    rsHomeAll = |(rise & portsWith(s_r.func, FN_HOMEALL));
    rsHomeInc = |(rise & portsWith(s_r.func, FN_HOMEINC));
    lvPermit = |(filtered & portsWith(s_r.func, FN_PERMIT));
    lvRemote = |(filtered & portsWith(s_r.func, FN_REMOTE));
    rawBrake[0] = |(filtered & portsWith(s_r.func, FN_BRAKE1));
    rawBrake[1] = |(filtered & portsWith(s_r.func, FN_BRAKE2));

    valid = s_r.axcfg[AX_VALID +: NAXES];
    incr = s_r.axcfg[AX_INCR +: NAXES];
    intDrv = s_r.axcfg[AX_INTDRV +: NAXES];

    // Upper program-number contribution.
    if (s_r.ctrl[CTRL_DECIMAL]) begin
      s_nxt.progHigh = (lvP5 ? WD5 : 7'h00) + (lvP6 ? WD6 : 7'h00) + (lvP7 ? WD7 : 7'h00);
    end else begin
      s_nxt.progHigh = (lvP5 ? WB5 : 7'h00) + (lvP6 ? WB6 : 7'h00) + (lvP7 ? WB7 : 7'h00);
    end

    // A new error in the clearing cycle survives the clear.
    s_nxt.errorActive = errorRaise || (s_r.errorActive && !rsErr);

    for (int a = 0; a < NAXES; a++) begin
      if (!intDrv[a]) begin
        s_nxt.cutoff[a] = 1'b0;
      end else if (cutoffCause[a]) begin
        s_nxt.cutoff[a] = 1'b1;
      end else if (rsCut) begin
        s_nxt.cutoff[a] = 1'b0;
      end
    end

    s_nxt.homeStart = ({NAXES{rsHomeAll}} & valid)
                    | ({NAXES{rsHomeInc}} & valid & incr);

    // Once operation runs, the permission is frozen at its last sample.
    if (!s_r.ctrl[CTRL_OPSTART]) begin
      s_nxt.permit = lvPermit;
    end

    s_nxt.manual = lvRemote || frontManual;

    s_nxt.brake = rawBrake;
    if (s_r.ctrl[CTRL_SYNCEN]) begin
      if (s_r.ctrl[CTRL_SYNCM2]) begin
        s_nxt.brake[0] = rawBrake[1];
      end else begin
        s_nxt.brake[1] = rawBrake[0];
      end
    end

    // Setup cycle: decode and present read data so the access phase ends at once.
    if (psel && !penable) begin
      s_nxt.pready = 1'b1;
      hit = 1'b1;
      unique case (APB_AW'(paddr))
        APB_AW'(REG_CTRL): begin
          rdata[CTRL_W-1:0] = s_r.ctrl;
        end
        APB_AW'(REG_AXCFG): begin
          rdata[AXCFG_W-1:0] = s_r.axcfg;
        end
        APB_AW'(REG_STATUS): begin
          rdata[ST_ERROR] = s_r.errorActive;
          rdata[ST_CUTOFF +: NAXES] = s_r.cutoff;
          rdata[ST_MANUAL] = s_r.manual;
          rdata[ST_PERMIT] = s_r.permit;
          rdata[ST_BRAKE +: NAXES] = s_r.brake;
          rdata[ST_PROG +: 7] = s_r.progHigh;
        end
        APB_AW'(REG_LEVELS): begin
          rdata[NPORTS-1:0] = s_r.prevIn;
        end
        default: begin
          hit = 1'b0;
          for (int i = 0; i < NPORTS; i++) begin
            if (paddr == funcAddr(i)) begin
              hit = 1'b1;
              rdata[FUNC_W-1:0] = s_r.func[i];
            end
          end
        end
      endcase
      s_nxt.prdata = hit ? rdata : 32'h00000000;
      s_nxt.pslverr = !hit;
    end

    // Writes take effect at the access edge; status and levels are read-only.
    if (psel && penable && pwrite && s_r.pready && !s_r.pslverr) begin
      if (paddr == APB_AW'(REG_CTRL)) begin
        s_nxt.ctrl = pwdata[CTRL_W-1:0];
      end
      if (paddr == APB_AW'(REG_AXCFG)) begin
        s_nxt.axcfg = pwdata[AXCFG_W-1:0];
      end
      for (int i = 0; i < NPORTS; i++) begin
        if (paddr == funcAddr(i)) begin
          s_nxt.func[i] = pwdata[FUNC_W-1:0];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_r <= '0;
      s_r.ctrl <= CTRL_RESET;
      s_r.axcfg <= AXCFG_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign errorActive = s_r.errorActive;
  assign driveCutoff = s_r.cutoff;
  assign homeStart = s_r.homeStart;
  assign brakeRelease = s_r.brake;
  assign manualOperationMode = s_r.manual;
  assign hostOrPendantPermit = s_r.permit;
  assign progHighNumber = s_r.progHigh;

endmodule

`default_nettype wire

/* File: src/ipd_pkg.sv */
// Purpose: Shared constants for the input-port function dispatcher.
// Assumes: APB slave with 32-bit data, one clock, synchronous active-high reset.
// Notes: Offsets are byte addresses; each register is one aligned word.
//
// Operation
// - Program-number bits 5, 6, 7 weigh 16, 32, 64 in binary and 10, 20, 40 in decimal mode.
// - A port set to function 16 clears the present error on every rising edge of its input.
// - Function 17 resets the drive cutoff on a rising edge, only once its cause is gone.
// - Axes whose drive power or cutoff circuit is not ours get no cutoff control at all.
// - Function 18 starts homing of every valid axis on a rising edge.
// - Function 19 starts homing of the valid incremental-encoder axes only, on a rising edge.
// - The movement permission input, function 20, is sampled only until operation starts.
// - Function 21 high or the front selector at manual gives manual mode, else auto mode.
// - The port that carries function 21 bypasses the input filter.
// - While a function 22 port is high the axis 1 brake is forced released.
// - While a function 23 port is high the axis 2 brake is forced released.
// - With two axes synchronized, the slave brake follows the master brake, not its own input.

package ipd_pkg;

  localparam int APB_AW = 12;
  localparam int NPORTS_DEF = 8;
  localparam int NAXES = 2;
  localparam int FUNC_W = 5;

  // Register map.
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_AXCFG = 12'h004;
  localparam logic [11:0] REG_STATUS = 12'h008;
  localparam logic [11:0] REG_LEVELS = 12'h00c;
  localparam logic [11:0] REG_FUNC_BASE = 12'h040;

  // Control register fields.
  localparam int CTRL_DECIMAL = 0;
  localparam int CTRL_OPSTART = 1;
  localparam int CTRL_FILTEN = 2;
  localparam int CTRL_SYNCEN = 3;
  localparam int CTRL_SYNCM2 = 4;
  localparam int CTRL_W = 5;
  localparam logic [4:0] CTRL_RESET = 5'h04;

  // Axis configuration fields: valid, incremental, internal drive, two bits each.
  localparam int AX_VALID = 0;
  localparam int AX_INCR = 2;
  localparam int AX_INTDRV = 4;
  localparam int AXCFG_W = 6;
  localparam logic [5:0] AXCFG_RESET = 6'h33;

  // Status register fields.
  localparam int ST_ERROR = 0;
  localparam int ST_CUTOFF = 1;
  localparam int ST_MANUAL = 3;
  localparam int ST_PERMIT = 4;
  localparam int ST_BRAKE = 5;
  localparam int ST_PROG = 8;

  // Function values.
  localparam logic [4:0] FN_PROG5 = 5'h0d;
  localparam logic [4:0] FN_PROG6 = 5'h0e;
  localparam logic [4:0] FN_PROG7 = 5'h0f;
  localparam logic [4:0] FN_ERRRST = 5'h10;
  localparam logic [4:0] FN_CUTRST = 5'h11;
  localparam logic [4:0] FN_HOMEALL = 5'h12;
  localparam logic [4:0] FN_HOMEINC = 5'h13;
  localparam logic [4:0] FN_PERMIT = 5'h14;
  localparam logic [4:0] FN_REMOTE = 5'h15;
  localparam logic [4:0] FN_BRAKE1 = 5'h16;
  localparam logic [4:0] FN_BRAKE2 = 5'h17;

  // Program-number weights of bits 5, 6 and 7.
  localparam logic [6:0] WB5 = 7'h10;
  localparam logic [6:0] WB6 = 7'h20;
  localparam logic [6:0] WB7 = 7'h40;
  localparam logic [6:0] WD5 = 7'h0a;
  localparam logic [6:0] WD6 = 7'h14;
  localparam logic [6:0] WD7 = 7'h28;

  // Hold time the outside party keeps program bits; informs the filter only.
  localparam int PROG_HOLD_MS = 100;
  localparam int FILT_CYCLES_DEF = 16;

endpackage

/* File: tb/ipd_partner.sv */
// Purpose: Outside machine wiring that drives the discrete input ports.
// Assumes: Levels change just after a rising clock edge.
// Notes: SLOW from 1 to 4 delays every level by that many cycles; above 4 it wraps, so 5 acts as 1 and 8 as 4.
`timescale 1ns/1ns
`default_nettype none
module ipd_partner #(
  parameter int SLOW = 0
) (
  input wire logic clk,
  input wire logic [7:0] want,
  output logic [7:0] port
);
  logic [7:0] pipe [4];
  // Servos are taken as on before any homing level rises.
  // Each go step holds a level only 4 cycles, shorter than the 6-cycle bench filter.
  always @(posedge clk) begin
    pipe[0] <= want;
    for (int i = 1; i < 4; i++) pipe[i] <= pipe[i-1];
  end
  assign port = (SLOW == 0) ? want : pipe[(SLOW - 1) % 4];
endmodule
`default_nettype wire

/* File: tb/ipd_sva.sv */
// Purpose: Port-level checks for the input-port function dispatcher.
// Assumes: One clock; reset is synchronous and active high.
// Notes: Sees only the top module's ports.
`timescale 1ns/1ns
`default_nettype none
module ipd_sva (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic frontManual,
  input wire logic errorRaise,
  input wire logic [1:0] cutoffCause,
  input wire logic errorActive,
  input wire logic [1:0] driveCutoff,
  input wire logic [1:0] homeStart,
  input wire logic manualOperationMode,
  input wire logic [6:0] progHighNumber
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("pready stands too long");
  a_error_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_home_single_pulse: assert property (|homeStart |=> (homeStart & $past(homeStart)) == 2'h0)
    else $error("home pulse longer than one cycle");
  a_cutoff_held: assert property (driveCutoff[0] && cutoffCause[0] |=> driveCutoff[0])
    else $error("cutoff cleared while cause present");
  a_error_set: assert property (errorRaise |-> ##[1:2] errorActive)
    else $error("error not raised");
  a_manual_front: assert property (frontManual [*3] |-> manualOperationMode)
    else $error("front selector ignored");
  a_prog_weights: assert property (progHighNumber % 16 == 0 ||
    (progHighNumber % 10 == 0 && progHighNumber <= 7'h46))
    else $error("program number off the weights");
endmodule
bind ipd_input_dispatch ipd_sva u_sva(.clk, .reset, .psel, .penable, .pready, .pslverr,
  .frontManual, .errorRaise, .cutoffCause, .errorActive, .driveCutoff, .homeStart,
  .manualOperationMode, .progHighNumber);
`default_nettype wire

/* File: tb/tb.sv */
// Purpose: Self-checking bench for the input-port function dispatcher.
// Assumes: Filter set short so the hold test stays brief.
// Notes: Table rows drive port 0 through each level function.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import ipd_pkg::*;
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, frontManual = 0;
  logic errorRaise = 0, pready, pslverr, er, errorActive, manualOperationMode;
  logic hostOrPendantPermit;
  logic [11:0] paddr = '0, obs;
  logic [31:0] pwdata = '0, prdata, rd;
  logic [1:0] cutoffCause = '0, driveCutoff, homeStart, brakeRelease, hv;
  logic [6:0] progHighNumber;
  logic [7:0] want = '0, din;
  int badCount = 0, cmpCount = 0, cyc = 0, hits;
  logic [16:0] rows [11] = '{{5'h0d, 12'h100}, {5'h0e, 12'h200}, {5'h0f, 12'h400},
    {5'h14, 12'h004}, {5'h15, 12'h008}, {5'h16, 12'h001}, {5'h17, 12'h002},
    {5'h18, 12'h000}, {5'h19, 12'h000}, {5'h1a, 12'h000}, {5'h1b, 12'h000}};
  assign obs = {errorActive, progHighNumber, manualOperationMode, hostOrPendantPermit,
    brakeRelease};
  ipd_partner u_far(.clk, .want, .port(din));
  ipd_input_dispatch #(.FILT_CYCLES(6)) u_dut(.clk, .reset, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .discreteInputPort(din), .frontManual,
    .errorRaise, .cutoffCause, .errorActive, .driveCutoff, .homeStart, .brakeRelease,
    .manualOperationMode, .hostOrPendantPermit, .progHighNumber);
  always #2 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 3000) begin
      badCount++;
      reportAndStop;
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmpCount++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Answers are read mid-cycle so they are settled, then the request is released after the edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    logic seen;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(negedge clk);
      seen = pready;
      rd = prdata;
      er = pslverr;
      @(posedge clk);
    end while (seen !== 1'b1);
    psel <= 0;
    penable <= 0;
  endtask
  task automatic setf(input logic [4:0] f);
    apb(1, REG_FUNC_BASE, {27'h0, f});
  endtask
  task automatic go(input logic [7:0] v);
    want <= v;
    repeat (4) @(posedge clk);
  endtask
  task automatic pulse();
    hits = 0;
    want <= 8'h01;
    repeat (5) begin
      @(negedge clk);
      if (homeStart !== 2'h0) hv = homeStart;
      if (homeStart !== 2'h0) hits++;
    end
    @(posedge clk);
  endtask
  task automatic reportAndStop;
    $display("comparisons %0d, mismatches %0d", cmpCount, badCount);
    if (badCount == 0 && cmpCount > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    reset <= 0;
    apb(0, REG_CTRL, 0);
    chk(rd, 32'h04);
    apb(0, REG_AXCFG, 0);
    chk(rd, 32'h33);
    apb(0, 12'h800, 0);
    chk({31'h0, er}, 32'h1);
    apb(1, REG_CTRL, 0);
    foreach (rows[i]) begin
      setf(rows[i][16:12]);
      go(8'h01);
      chk({20'h0, obs}, {20'h0, rows[i][11:0]});
      go(8'h00);
    end
    $display("function table done");
    for (int p = 0; p < 3; p++) apb(1, REG_FUNC_BASE + 12'(4 * p), 32'(FN_PROG5 + p));
    for (int m = 0; m < 2; m++) begin
      apb(1, REG_CTRL, 32'(m));
      go(8'h07);
      chk({25'h0, progHighNumber}, m ? 32'h46 : 32'h70);
      go(8'h00);
    end
    apb(1, REG_AXCFG, 32'h37);
    for (int k = 0; k < 2; k++) begin
      setf(5'(FN_HOMEALL + k));
      pulse();
      chk(32'(hits), 32'h1);
      chk({30'h0, hv}, k ? 32'h1 : 32'h3);
      go(8'h00);
    end
    errorRaise <= 1;
    @(posedge clk);
    errorRaise <= 0;
    setf(FN_ERRRST);
    chk({31'h0, errorActive}, 32'h1);
    go(8'h01);
    chk({31'h0, errorActive}, 32'h0);
    go(8'h00);
    // Axis 2 loses its own drive so the cutoff must stay away from it.
    apb(1, REG_AXCFG, 32'h13);
    cutoffCause <= 2'h3;
    setf(FN_CUTRST);
    go(8'h01);
    chk({30'h0, driveCutoff}, 32'h1);
    cutoffCause <= 2'h0;
    go(8'h00);
    chk({30'h0, driveCutoff}, 32'h1);
    go(8'h01);
    chk({30'h0, driveCutoff}, 32'h0);
    setf(FN_PERMIT);
    apb(1, REG_CTRL, 32'h02);
    go(8'h00);
    chk({31'h0, hostOrPendantPermit}, 32'h1);
    frontManual <= 1;
    go(8'h00);
    chk({31'h0, manualOperationMode}, 32'h1);
    frontManual <= 0;
    apb(1, REG_CTRL, 32'h04);
    setf(FN_REMOTE);
    go(8'h01);
    chk({31'h0, manualOperationMode}, 32'h1);
    go(8'h00);
    setf(FN_BRAKE1);
    go(8'h01);
    chk({30'h0, brakeRelease}, 32'h0);
    go(8'h01);
    go(8'h01);
    chk({30'h0, brakeRelease}, 32'h1);
    apb(1, REG_CTRL, 32'h0c);
    go(8'h01);
    chk({30'h0, brakeRelease}, 32'h3);
    apb(0, REG_STATUS, 0);
    chk(rd, 32'h60);
    setf(FN_BRAKE2);
    go(8'h01);
    chk({30'h0, brakeRelease}, 32'h0);
    $display("hand tests done");
    errorRaise <= 1;
    @(posedge clk);
    errorRaise <= 0;
    reset <= 1;
    repeat (2) @(posedge clk);
    reset <= 0;
    chk({31'h0, errorActive}, 32'h0);
    apb(0, REG_CTRL, 0);
    chk(rd, 32'h04);
    apb(0, REG_FUNC_BASE, 0);
    chk(rd, 32'h0);
    $display("reset test done");
    reportAndStop;
  end
endmodule
`default_nettype wire
